// file: common/iafd_pkg.sv
/*
  Shared constants and types for the addressing, FIFO, interactive receive
  and DMA request block of the two-wire controller.
  Assumes a 25 MHz register-side clock; the link side runs on its own clock.
*/
package iafd_pkg;

  // Data path widths and FIFO geometry
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 4;
  localparam int BUS_W = 32;
  localparam int ADDR10_W = 10;
  localparam int TXTH_W = 3;
  localparam int RXTH_W = 4;

  // Byte values and bus encodings
  localparam logic [7:0] EMPTY_BYTE = 8'hff;
  localparam logic [4:0] TEN_PREFIX = 5'h1e;
  localparam logic RW_READ = 1'h1;
  localparam logic RW_WRITE = 1'h0;
  localparam logic ACK = 1'h0;
  localparam logic NACK = 1'h1;

  // Timing: least SCL low time before the interactive answer is released
  localparam int CLK_NS = 40;
  localparam int SCL_LOW_NS = 1300;
  localparam int SCL_LOW_CYC = (SCL_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_W = 6;
  localparam logic [SETUP_W-1:0] SETUP_LOAD = SETUP_W'(SCL_LOW_CYC - 1);

  // Link request kinds and request info bit positions
  localparam logic KIND_RX = 1'h0;
  localparam logic KIND_TX = 1'h1;
  localparam int INF_ADDR = 0;
  localparam int INF_READ = 1;
  localparam int INF_GC = 2;
  localparam int INF_PHASE = 3;
  localparam int INF_RESTART = 4;
  localparam int INF_W = 5;

  // Events that flush the transmit FIFO and lock its writes
  localparam int EV_GC = 0;
  localparam int EV_SADDR = 1;
  localparam int EV_STX_NACK = 2;
  localparam int EV_ARB = 3;
  localparam int EV_TIMEOUT = 4;
  localparam int EV_ADDR_NACK = 5;
  localparam int EV_DATA_NACK = 6;
  localparam int EV_START_ERR = 7;
  localparam int EV_STOP = 8;
  localparam int EV_W = 9;

  // Request handler states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_SETUP = 4'h4,
    ST_REPLY = 4'h8
  } iafd_state_t;

endpackage

// file: common/iafd_fifo_if.sv
/*
  Connection between the block's control logic and one byte FIFO.
  Assumes both ends run on the register-side clock.
*/
`timescale 1ns/100ps
interface iafd_fifo_if #(
  parameter int W = 8,
  parameter int CW = 4
);
  logic push;
  logic pop;
  logic flush;
  logic [W-1:0] wdata;
  logic [W-1:0] head;
  logic [CW-1:0] count;
  logic full;
  logic empty;

  modport owner (output push, output pop, output flush, output wdata,
                 input head, input count, input full, input empty);
  modport store (input push, input pop, input flush, input wdata,
                 output head, output count, output full, output empty);
endinterface

// file: core/iafd_byte_fifo.sv
/*
  Byte FIFO with flush, drop-on-full push and ignore-on-empty pop.
  Assumes a reset already synchronised to clk and a power-of-two depth.
*/
`timescale 1ns/100ps
module iafd_byte_fifo #(
  parameter int DEPTH = 8,
  parameter int W = 8,
  parameter int CW = 4
) (
  input wire logic clk,    // Register-side clock
  input wire logic rst_n,  // Synchronised reset, active low
  iafd_fifo_if.store f     // Push, pop and status
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  wire do_push = f.push && !f.full && !f.flush;
  wire do_pop = f.pop && !f.empty && !f.flush;

  // Status; a push into a full FIFO is simply lost
  assign f.full = (count == CW'(DEPTH));
  assign f.empty = (count == '0);
  assign f.count = count;
  assign f.head = mem[rd_ptr];

  // Storage has no reset; the count alone says what is valid
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= f.wdata;
    end
  end

  // Pointers and count; flush wins over everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (f.flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= do_push ? PW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= do_pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
      count <= CW'(count + CW'(do_push) - CW'(do_pop));
    end
  end
endmodule

// file: core/iafd_top.sv
/*
  Address byte formation, automatic NACK policy, transmit and receive FIFOs
  behind one data register, transmit lockout, interactive receive and DMA
  requests of a two-wire controller.
  Assumes a bit engine on link_clk that raises one request per byte and
  waits for the answer; configuration and event inputs are on ref_clk.
*/
`timescale 1ns/100ps
module iafd_top (
  input wire logic ref_clk,                          // Register-side clock
  input wire logic link_clk,                         // Bit engine clock
  input wire logic arst_n,                           // Asynchronous reset
  input wire logic port_enable,                      // Port on; low empties FIFOs
  input wire logic tx_flush,                         // Empty transmit FIFO
  input wire logic rx_flush,                         // Empty receive FIFO
  input wire logic ten_bit_mode,                     // Ten-bit addressing
  input wire logic [iafd_pkg::ADDR10_W-1:0] addr10,  // Ten-bit slave address
  input wire logic read10,                           // Ten-bit transfer is a read
  input wire logic do_not_respond,                   // NACK policy select
  input wire logic tx_ready,                         // Slave data ready for reads
  input wire logic tx_preload,                       // Keep data on address match
  input wire logic irxm_enable,                      // Interactive receive mode
  input wire logic irxm_ack_bit,                     // 0 ACK, 1 NACK
  input wire logic irxm_flag_clr,                    // Write-one clear
  input wire logic txlock_clr,                       // Write-one clear
  input wire logic dnr_flag_clr,                     // Write-one clear
  input wire logic [iafd_pkg::EV_W-1:0] lock_events, // Lockout event pulses
  input wire logic dma_tx_en,                        // Transmit DMA enable
  input wire logic dma_rx_en,                        // Receive DMA enable
  input wire logic [iafd_pkg::TXTH_W-1:0] tx_thresh, // 0 to 7
  input wire logic [iafd_pkg::RXTH_W-1:0] rx_thresh, // 1 to 8
  input wire logic fifo_data_register_wr,            // Data register write
  input wire logic [iafd_pkg::BUS_W-1:0] fifo_data_register_wdata, // Write data
  input wire logic fifo_data_register_rd,            // Data register read
  output logic [iafd_pkg::BUS_W-1:0] fifo_data_register_rdata,    // Read data
  output logic [iafd_pkg::CNT_W-1:0] tx_count,       // Transmit level
  output logic [iafd_pkg::CNT_W-1:0] rx_count,       // Receive level
  output logic txlock_flag,                          // Transmit lockout
  output logic irxm_flag,                            // Byte awaits answer
  output logic dnr_flag,                             // Do-not-respond NACK sent
  output logic dma_tx_req,                           // Transmit DMA request
  output logic dma_rx_req,                           // Receive DMA request
  input wire logic lk_req,                           // Byte request pulse
  input wire logic lk_req_kind,                      // Receive or transmit
  input wire logic [iafd_pkg::INF_W-1:0] lk_req_info, // Byte attributes
  input wire logic [iafd_pkg::DATA_W-1:0] lk_req_byte, // Received byte
  output logic lk_ready,                             // Free to accept a request
  output logic lk_scl_hold,                          // Hold SCL low
  output logic lk_done,                              // Answer pulse
  output logic lk_ack,                               // 0 ACK, 1 NACK
  output logic [iafd_pkg::DATA_W-1:0] lk_tx_byte,    // Byte to send
  output logic lk_tx_ok,                             // Byte valid
  output logic lk_restart_rd                         // Restart for read
);
  // Reset release in each domain
  logic rst_s1;
  logic rst_n;
  logic lk_rst_s1;
  logic lk_rst_n;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      lk_rst_s1 <= 1'b0;
      lk_rst_n <= 1'b0;
    end else begin
      lk_rst_s1 <= 1'b1;
      lk_rst_n <= lk_rst_s1;
    end
  end

  // Link side: capture a request, toggle it across, hold SCL until answered
  logic lk_kind;
  logic [iafd_pkg::INF_W-1:0] lk_info;
  logic [iafd_pkg::DATA_W-1:0] lk_byte;
  logic lk_rq_tgl;
  logic lk_busy;
  logic lk_rp_s1;
  logic lk_rp_s2;
  logic lk_rp_s3;
  logic rp_tgl;
  logic rp_ack;
  logic [iafd_pkg::DATA_W-1:0] rp_byte;
  logic rp_ok;
  logic rp_rst;
  wire lk_rp_edge = lk_rp_s2 ^ lk_rp_s3;
  wire lk_take = lk_req && !lk_busy;

  assign lk_ready = !lk_busy;
  assign lk_scl_hold = lk_busy;

  // Request fields stay frozen while busy, so the other side reads them safely
  always_ff @(posedge link_clk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_kind <= iafd_pkg::KIND_RX;
      lk_info <= '0;
      lk_byte <= '0;
      lk_rq_tgl <= 1'b0;
      lk_busy <= 1'b0;
    end else if (lk_take) begin
      lk_kind <= lk_req_kind;
      lk_info <= lk_req_info;
      lk_byte <= lk_req_byte;
      lk_rq_tgl <= !lk_rq_tgl;
      lk_busy <= 1'b1;
    end else if (lk_rp_edge) begin
      lk_busy <= 1'b0;
    end
  end

  // Answer crossing; answer fields are stable before the toggle moves
  always_ff @(posedge link_clk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_rp_s1 <= 1'b0;
      lk_rp_s2 <= 1'b0;
      lk_rp_s3 <= 1'b0;
      lk_done <= 1'b0;
      lk_ack <= iafd_pkg::ACK;
      lk_tx_byte <= '0;
      lk_tx_ok <= 1'b0;
      lk_restart_rd <= 1'b0;
    end else begin
      lk_rp_s1 <= rp_tgl;
      lk_rp_s2 <= lk_rp_s1;
      lk_rp_s3 <= lk_rp_s2;
      lk_done <= lk_rp_edge;
      if (lk_rp_edge) begin
        lk_ack <= rp_ack;
        lk_tx_byte <= rp_byte;
        lk_tx_ok <= rp_ok;
        lk_restart_rd <= rp_rst;
      end
    end
  end

  // FIFOs
  iafd_fifo_if #(.W(iafd_pkg::DATA_W), .CW(iafd_pkg::CNT_W)) txf ();
  iafd_fifo_if #(.W(iafd_pkg::DATA_W), .CW(iafd_pkg::CNT_W)) rxf ();

  iafd_byte_fifo #(.DEPTH(iafd_pkg::FIFO_DEPTH), .W(iafd_pkg::DATA_W),
                   .CW(iafd_pkg::CNT_W)) u_tx_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .f(txf)
  );

  iafd_byte_fifo #(.DEPTH(iafd_pkg::FIFO_DEPTH), .W(iafd_pkg::DATA_W),
                   .CW(iafd_pkg::CNT_W)) u_rx_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .f(rxf)
  );

  // Register side: request crossing and decoded request fields
  logic rq_s1;
  logic rq_s2;
  logic rq_s3;
  iafd_pkg::iafd_state_t state;
  iafd_pkg::iafd_state_t next_state;
  logic [iafd_pkg::SETUP_W-1:0] setup_cnt;
  logic nack_data;
  logic irxm_q;
  logic [iafd_pkg::DATA_W-1:0] irxm_byte;
  logic irxm_valid;
  logic irxm_stale;

  wire req_new = rq_s2 ^ rq_s3;
  wire take = (state == iafd_pkg::ST_IDLE) && req_new;
  wire is_tx = (lk_kind == iafd_pkg::KIND_TX);
  wire rq_addr = lk_info[iafd_pkg::INF_ADDR];
  wire rq_read = lk_info[iafd_pkg::INF_READ];
  wire rq_gc = lk_info[iafd_pkg::INF_GC];
  wire rq_phase = lk_info[iafd_pkg::INF_PHASE];
  wire rq_restart = lk_info[iafd_pkg::INF_RESTART];

  // Transmit byte selection; ten-bit bytes are built here, not taken from the FIFO
  wire ten_addr = rq_addr && ten_bit_mode;
  wire [iafd_pkg::DATA_W-1:0] ten_first = {iafd_pkg::TEN_PREFIX, addr10[9:8],
    rq_restart ? iafd_pkg::RW_READ : iafd_pkg::RW_WRITE};
  wire [iafd_pkg::DATA_W-1:0] ten_byte = rq_phase ? addr10[7:0] : ten_first;
  wire [iafd_pkg::DATA_W-1:0] tx_byte = ten_addr ? ten_byte : txf.head;
  wire tx_ok = ten_addr || !txf.empty;
  wire tx_rst = ten_addr && rq_phase && (read10 == iafd_pkg::RW_READ);

  // Receive answer policy
  wire wr_busy = !rq_read && !rxf.empty;
  wire nack_read = rq_read && !tx_ready;
  wire nack_dnr = wr_busy && do_not_respond && !nack_read;
  wire addr_nack = nack_read || nack_dnr;
  wire rx_ack = rq_addr ? addr_nack : nack_data;
  wire irxm_take = !rq_addr && !rq_gc && irxm_enable;
  wire rx_take = take && !is_tx;
  wire dnr_hit = rx_take && rq_addr && nack_dnr;

  // Data register read path
  wire irxm_rd = fifo_data_register_rd && irxm_enable && irxm_valid;
  wire stale_rd = fifo_data_register_rd && !irxm_rd && irxm_stale;
  wire stale_set = irxm_q && !irxm_enable && irxm_valid;
  wire [iafd_pkg::DATA_W-1:0] rd_byte = irxm_rd ? irxm_byte :
    (stale_rd || rxf.empty) ? iafd_pkg::EMPTY_BYTE : rxf.head;

  // Lockout; preload shields only the two address-match events
  wire [iafd_pkg::EV_W-1:0] lock_mask = tx_preload ?
    ~((iafd_pkg::EV_W)'(1) << iafd_pkg::EV_GC | (iafd_pkg::EV_W)'(1) << iafd_pkg::EV_SADDR)
    : '1;
  wire lock_hit = |(lock_events & lock_mask);

  // FIFO controls
  assign txf.flush = !port_enable || tx_flush || lock_hit;
  assign rxf.flush = !port_enable || rx_flush;
  assign txf.push = fifo_data_register_wr && !txlock_flag;
  assign txf.wdata = fifo_data_register_wdata[iafd_pkg::DATA_W-1:0];
  assign txf.pop = take && is_tx && !ten_addr;
  assign rxf.push = rx_take && !rq_addr && !irxm_take && !nack_data;
  assign rxf.wdata = lk_byte;
  assign rxf.pop = fifo_data_register_rd && !irxm_rd && !stale_rd;
  assign tx_count = txf.count;
  assign rx_count = rxf.count;

  // DMA requests follow FIFO levels directly
  assign dma_tx_req = dma_tx_en && (txf.count <= iafd_pkg::CNT_W'(tx_thresh));
  assign dma_rx_req = dma_rx_en && (rxf.count >= rx_thresh);

  // Request crossing from the link domain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rq_s1 <= 1'b0;
      rq_s2 <= 1'b0;
      rq_s3 <= 1'b0;
    end else begin
      rq_s1 <= lk_rq_tgl;
      rq_s2 <= rq_s1;
      rq_s3 <= rq_s2;
    end
  end

  // Handler: answer at once, or park for firmware in interactive mode
  always_comb begin
    next_state = state;
    case (state)
      iafd_pkg::ST_IDLE: begin
        if (take) begin
          next_state = (!is_tx && irxm_take) ? iafd_pkg::ST_WAIT : iafd_pkg::ST_REPLY;
        end
      end
      iafd_pkg::ST_WAIT: begin
        if (irxm_flag_clr) begin
          next_state = iafd_pkg::ST_SETUP;
        end
      end
      iafd_pkg::ST_SETUP: begin
        if (setup_cnt == '0) begin
          next_state = iafd_pkg::ST_REPLY;
        end
      end
      iafd_pkg::ST_REPLY: begin
        next_state = iafd_pkg::ST_IDLE;
      end
      default: begin
        next_state = iafd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= iafd_pkg::ST_IDLE;
      setup_cnt <= '0;
    end else begin
      state <= next_state;
      // Keeps SCL low long enough for data setup after the late answer
      setup_cnt <= (state == iafd_pkg::ST_WAIT) ? iafd_pkg::SETUP_LOAD :
                   (setup_cnt != '0) ? setup_cnt - 1'b1 : setup_cnt;
    end
  end

  // Answer fields; the toggle moves at least one cycle after they settle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rp_tgl <= 1'b0;
      rp_ack <= iafd_pkg::ACK;
      rp_byte <= '0;
      rp_ok <= 1'b0;
      rp_rst <= 1'b0;
    end else begin
      if (take) begin
        rp_ack <= is_tx ? iafd_pkg::ACK : rx_ack;
        rp_byte <= is_tx ? tx_byte : lk_byte;
        rp_ok <= is_tx ? tx_ok : 1'b1;
        rp_rst <= is_tx && tx_rst;
      end else if (state == iafd_pkg::ST_WAIT && irxm_flag_clr) begin
        rp_ack <= irxm_ack_bit;
      end
      if (state == iafd_pkg::ST_REPLY) begin
        rp_tgl <= !rp_tgl;
      end
    end
  end

  // Data NACK after a write address while the receive FIFO was busy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nack_data <= 1'b0;
    end else if (rx_take && rq_addr) begin
      nack_data <= wr_busy && !do_not_respond;
    end
  end

  // Sticky flags: a set in the same cycle as the clear wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txlock_flag <= 1'b0;
      dnr_flag <= 1'b0;
      irxm_flag <= 1'b0;
    end else begin
      txlock_flag <= lock_hit || (txlock_flag && !txlock_clr);
      dnr_flag <= dnr_hit || (dnr_flag && !dnr_flag_clr);
      irxm_flag <= (rx_take && irxm_take) || (irxm_flag && !irxm_flag_clr);
    end
  end

  // Interactive byte bypasses the receive FIFO
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irxm_q <= 1'b0;
      irxm_byte <= '0;
      irxm_valid <= 1'b0;
      irxm_stale <= 1'b0;
    end else begin
      irxm_q <= irxm_enable;
      if (rx_take && irxm_take) begin
        irxm_byte <= lk_byte;
      end
      irxm_valid <= (rx_take && irxm_take) || (irxm_valid && !irxm_rd && !stale_set);
      // An unread byte at mode exit costs the next read one dummy all-ones byte
      irxm_stale <= stale_set || (irxm_stale && !stale_rd);
    end
  end

  // Read data from a flop; upper lanes always zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_data_register_rdata <= '0;
    end else if (fifo_data_register_rd) begin
      fifo_data_register_rdata <= {{(iafd_pkg::BUS_W - iafd_pkg::DATA_W){1'b0}}, rd_byte};
    end
  end

  // Checks on the register side, and one on the link side
  a_lock_set_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lock_hit ##1 !txlock_clr |=> txlock_flag && txf.empty)
    else $error("lockout flag not held after event");
  a_lock_blocks_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    txlock_flag && !txf.flush && !txf.pop |=> $stable(txf.count))
    else $error("write accepted during lockout");
  a_full_write_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    txf.full && !txf.pop && !txf.flush |=> txf.full)
    else $error("full transmit FIFO changed level");
  a_empty_read_ones: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fifo_data_register_rd && rxf.empty && !irxm_rd
    |=> fifo_data_register_rdata == {24'h000000, iafd_pkg::EMPTY_BYTE})
    else $error("empty read did not return all ones");
  a_disable_flushes: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !port_enable |=> txf.empty && rxf.empty)
    else $error("FIFOs not emptied while disabled");
  a_ten_bit_prefix: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && is_tx && ten_addr && !rq_phase && !rq_restart
    |=> rp_byte[7:3] == iafd_pkg::TEN_PREFIX && rp_byte[0] == iafd_pkg::RW_WRITE)
    else $error("ten-bit prefix byte malformed");
  a_read_not_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_take && rq_addr && rq_read && !tx_ready |=> rp_ack == iafd_pkg::NACK ##1 rp_tgl != $past(rp_tgl))
    else $error("read not NACKed when transmit not ready");
  a_irxm_setup_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == iafd_pkg::ST_WAIT && irxm_flag_clr |=> (state == iafd_pkg::ST_SETUP)[*8])
    else $error("interactive answer released too early");
  a_irxm_flag_raise: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_take && irxm_take |=> irxm_flag && state == iafd_pkg::ST_WAIT)
    else $error("interactive flag not raised");
  a_dma_rx_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dma_rx_en && rxf.count >= rx_thresh && !rxf.flush && !rxf.pop |=> dma_rx_req)
    else $error("receive DMA request dropped at threshold");
  a_scl_hold_busy: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    lk_take |=> lk_scl_hold && !lk_ready)
    else $error("SCL not held after byte request");
endmodule

// file: test/iafd_link_model.sv
/*
  Bit engine stand-in: raises one byte request on link_clk, waits for the answer.
  Assumes the block's one-outstanding request handshake.
*/
`timescale 1ns/100ps
module iafd_link_model (
  input wire logic link_clk,  // Link clock
  input wire logic lk_ready,  // Block free
  input wire logic lk_done,   // Answer pulse
  output logic lk_req,        // Request
  output logic lk_req_kind,   // Receive or transmit
  output logic [iafd_pkg::INF_W-1:0] lk_req_info, // Byte attributes
  output logic [7:0] lk_req_byte // Received byte
);
  initial {lk_req, lk_req_kind, lk_req_info, lk_req_byte} = 15'h005a;
  // Held from after an edge until an edge with ready high; released info and byte lines are scrambled, kind is left
  task automatic xfer(input logic k, input logic [4:0] inf, input logic [7:0] b);
    do @(negedge link_clk); while (lk_ready !== 1'b1);
    #0.5;
    {lk_req, lk_req_kind, lk_req_info, lk_req_byte} = {1'b1, k, inf, b};
    @(posedge link_clk);
    #0.5;
    {lk_req, lk_req_info, lk_req_byte} = {1'b0, ~inf, ~b};
    for (int w = 0; w < 3000 && lk_done !== 1'b1; w++) @(posedge link_clk) #0.5;
  endtask
endmodule

// file: test/tb.sv
/*
  Self-checking bench for the addressing, FIFO, lockout, interactive and DMA block.
  Assumes the link model drives the bit engine side.
*/
`timescale 1ns/100ps
module tb;
  logic ref_clk = 0, link_clk = 0, arst_n = 0, port_enable = 0, tx_flush = 0, rx_flush = 0;
  logic ten_bit_mode = 0, read10 = 0, do_not_respond = 0, tx_ready = 0, tx_preload = 0;
  logic irxm_enable = 0, irxm_ack_bit = 0, irxm_flag_clr = 0, txlock_clr = 0;
  logic dnr_flag_clr = 0, dma_tx_en = 0, dma_rx_en = 0, wr = 0, rd = 0;
  logic [9:0] addr10 = 0;
  logic [8:0] lock_events = 0;
  logic [2:0] tx_thresh = 0;
  logic [3:0] rx_thresh = 1, tx_count, rx_count;
  logic [31:0] wd = 0, rdata, s = 35517;
  logic txlock_flag, irxm_flag, dnr_flag, dma_tx_req, dma_rx_req, lk_req, lk_req_kind;
  logic lk_ready, lk_scl_hold, lk_done, lk_ack, lk_tx_ok, lk_restart_rd;
  logic [4:0] lk_req_info;
  logic [7:0] lk_req_byte, lk_tx_byte, b;
  int fails = 0, n_checks = 0;
  // Clocks with unrelated periods and phases
  initial forever #20 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  iafd_top iafd_top_i (.ref_clk, .link_clk, .arst_n, .port_enable, .tx_flush, .rx_flush,
    .ten_bit_mode, .addr10, .read10, .do_not_respond, .tx_ready, .tx_preload, .irxm_enable,
    .irxm_ack_bit, .irxm_flag_clr, .txlock_clr, .dnr_flag_clr, .lock_events, .dma_tx_en,
    .dma_rx_en, .tx_thresh, .rx_thresh, .fifo_data_register_wr(wr),
    .fifo_data_register_wdata(wd), .fifo_data_register_rd(rd),
    .fifo_data_register_rdata(rdata), .tx_count, .rx_count, .txlock_flag, .irxm_flag,
    .dnr_flag, .dma_tx_req, .dma_rx_req, .lk_req, .lk_req_kind, .lk_req_info, .lk_req_byte,
    .lk_ready, .lk_scl_hold, .lk_done, .lk_ack, .lk_tx_byte, .lk_tx_ok, .lk_restart_rd);
  iafd_link_model iafd_link_model_i (.link_clk, .lk_ready, .lk_done, .lk_req, .lk_req_kind,
    .lk_req_info, .lk_req_byte);
  // Xorshift keeps the random stream repeatable
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [7:0] pfx(input logic [9:0] a, input logic rw);
    return {iafd_pkg::TEN_PREFIX, a[9:8], rw};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Inputs move on falling edges, away from the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wrb(input logic [31:0] v);
    {wr, wd} = {1'b1, v};
    cyc(1);
    wr = 0;
    cyc(1);
  endtask
  task automatic rdb();
    rd = 1;
    cyc(1);
    rd = 0;
    cyc(1);
  endtask
  task automatic ev(input int e);
    lock_events = 9'h001 << e;
    cyc(1);
    lock_events = 0;
    cyc(2);
  endtask
  task automatic lx(input logic k, input logic [4:0] inf, input logic [7:0] v);
    iafd_link_model_i.xfer(k, inf, v);
    cyc(3);
  endtask
  task automatic summarize();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    fails++;
    summarize();
  end
  initial begin
    cyc(8);
    arst_n = 1;
    cyc(4);
    chk({tx_count, rx_count, txlock_flag, irxm_flag, dnr_flag}, 0);
    {port_enable, dma_tx_en} = 2'b11;
    tx_thresh = 3'(rnd());
    // Let the combinational request settle before the first look
    cyc(1);
    // Fill past full; the request follows the level
    for (int i = 0; i < 10; i++) begin
      chk(dma_tx_req, (i > 8 ? 8 : i) <= tx_thresh);
      wrb(rnd());
    end
    chk(tx_count, 8);
    tx_flush = 1;
    cyc(1);
    tx_flush = 0;
    cyc(1);
    chk(tx_count, 0);
    for (int e = 0; e < 9; e++) begin
      wrb(rnd());
      ev(e);
      chk({txlock_flag, tx_count}, 5'h10);
      wrb(rnd());
      chk(tx_count, 0);
      txlock_clr = 1;
      cyc(1);
      txlock_clr = 0;
      cyc(1);
    end
    tx_preload = 1;
    b = 8'(rnd());
    wrb({24'(rnd()), b});
    ev(0);
    ev(1);
    chk({txlock_flag, tx_count}, 5'h01);
    lx(iafd_pkg::KIND_TX, 5'h01, 8'h00);
    chk({lk_tx_ok, lk_tx_byte}, {1'b1, b});
    {ten_bit_mode, read10} = 2'b11;
    addr10 = 10'(rnd());
    lx(iafd_pkg::KIND_TX, 5'h01, 8'h00);
    chk(lk_tx_byte, pfx(addr10, iafd_pkg::RW_WRITE));
    lx(iafd_pkg::KIND_TX, 5'h09, 8'h00);
    chk({lk_restart_rd, lk_tx_byte}, {1'b1, addr10[7:0]});
    lx(iafd_pkg::KIND_TX, 5'h13, 8'h00);
    chk(lk_tx_byte, pfx(addr10, iafd_pkg::RW_READ));
    {ten_bit_mode, dma_rx_en} = 2'b01;
    rdb();
    chk(rdata, 32'h0000_00ff);
    b = 8'(rnd());
    lx(iafd_pkg::KIND_RX, 5'h00, b);
    chk({lk_ack, rx_count, dma_rx_req}, 6'h03);
    // Busy receive FIFO with do-not-respond clear: address ACKed, data NACKed and dropped
    lx(iafd_pkg::KIND_RX, 5'h01, 8'h20);
    chk(lk_ack, iafd_pkg::ACK);
    lx(iafd_pkg::KIND_RX, 5'h00, 8'h55);
    chk({lk_ack, rx_count}, 5'h11);
    do_not_respond = 1;
    lx(iafd_pkg::KIND_RX, 5'h01, 8'h20);
    chk({lk_ack, dnr_flag}, 2'b11);
    dnr_flag_clr = 1;
    cyc(1);
    dnr_flag_clr = 0;
    chk(dnr_flag, 0);
    // DMA stand-in: burst equal to the receive threshold of one
    rdb();
    chk(rdata, {24'h0, b});
    chk(dma_rx_req, 0);
    lx(iafd_pkg::KIND_RX, 5'h03, 8'h21);
    chk(lk_ack, iafd_pkg::NACK);
    irxm_enable = 1;
    b = 8'(rnd());
    fork
      lx(iafd_pkg::KIND_RX, 5'h00, b);
      begin
        for (int i = 0; i < 500 && irxm_flag !== 1'b1; i++) cyc(1);
        chk({irxm_flag, lk_scl_hold}, 2'b11);
        rdb();
        chk(rdata, {24'h0, b});
        {irxm_ack_bit, irxm_flag_clr} = 2'b11;
        cyc(1);
        irxm_flag_clr = 0;
      end
    join
    chk({lk_ack, irxm_flag, rx_count}, 6'h20);
    // Unread interactive byte at mode exit: next read gives ones, then real data
    fork
      lx(iafd_pkg::KIND_RX, 5'h00, 8'hc3);
      begin
        for (int i = 0; i < 500 && irxm_flag !== 1'b1; i++) cyc(1);
        {irxm_ack_bit, irxm_flag_clr} = 2'b01;
        cyc(1);
        {irxm_enable, irxm_flag_clr} = 2'b00;
      end
    join
    chk({lk_ack, irxm_flag, rx_count}, 6'h00);
    lx(iafd_pkg::KIND_RX, 5'h00, 8'h3c);
    rdb();
    chk(rdata, 32'h0000_00ff);
    rdb();
    chk(rdata, 32'h0000_003c);
    // Receive flush empties a non-empty FIFO
    lx(iafd_pkg::KIND_RX, 5'h00, 8'h77);
    rx_flush = 1;
    cyc(1);
    rx_flush = 0;
    cyc(1);
    chk(rx_count, 0);
    summarize();
  end
endmodule
